// File: clock_select_regs.vh
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

// ==========================================================
// register indices on the register port
`define ADDR_CLOCK_DIVISOR 4'h0
`define ADDR_PLL_FEEDBACK 4'h1
`define ADDR_FAST_RC_TUNING 4'h2
`define ADDR_CLOCK_STATUS 4'h3

// ==========================================================
// clock divisor register fields
`define CDIV_FRC_DIV_HI 10
`define CDIV_FRC_DIV_LO 8
`define CDIV_POST_HI 7
`define CDIV_POST_LO 6
`define CDIV_PRE_HI 4
`define CDIV_PRE_LO 0

// pll feedback and tuning fields
`define FBD_HI 8
`define FBD_LO 0
`define TUNE_HI 5
`define TUNE_LO 0

// status register fields
`define STAT_SEL_HI 2
`define STAT_SEL_LO 0
`define STAT_MODE_HI 5
`define STAT_MODE_LO 4
`define STAT_PLL_BIT 6
`define STAT_LOADED_BIT 7

// ==========================================================
// reset values
`define RST_FRC_DIV 3'h0
`define RST_POST 2'h0
`define RST_PRE 5'h00
`define RST_FBD 9'h030
`define RST_TUNE 6'h00
`define RST_DATA 16'h0000

// ==========================================================
// initial oscillator select encodings
`define OSC_FRC 3'h0
`define OSC_FRC_PLL 3'h1
`define OSC_PRI 3'h2
`define OSC_PRI_PLL 3'h3
`define OSC_SEC 3'h4
`define OSC_LOW_POWER_RC_OSCILLATOR 3'h5
`define OSC_FRC_DIV16 3'h6
`define OSC_FRC_DIVN 3'h7

// primary oscillator mode encodings
`define PMODE_EC 2'h0
`define PMODE_XT 2'h1
`define PMODE_HS 2'h2
`define PMODE_OFF 2'h3

// postscale codes and their shift counts
`define POST_DIV2 2'h0
`define POST_DIV4 2'h1
`define POST_RSVD 2'h2
`define POST_DIV8 2'h3
`define POST_SHIFT2 2'h1
`define POST_SHIFT4 2'h2
`define POST_SHIFT8 2'h3
`define POST_BASE 9'h001

// ==========================================================
// factor offsets and fixed dividers
`define PRE_OFFSET 6'h02
`define FBD_OFFSET 10'h002
`define FRC_DIVN_BASE 9'h002
`define FRC_DIV16_LAST 8'h0F
`define ACC_MAX 12'h7FF

// oscillator source slots in the pin synchroniser
`define SRC_FRC 0
`define SRC_PRI 1
`define SRC_SEC 2
`define SRC_LOW_POWER_RC_OSCILLATOR 3
`define SRC_COUNT 4

`endif

// File: system_clock_select_pll.v
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "clock_select_regs.vh"

// Operation
// - eight system clock choices: fast rc, rc pll, primary, primary pll, secondary, low_power_rc_oscillator, rc by sixteen, rc postscaled
// - fast rc divided by two to two hundred fifty-six from three-bit field
// - software trims fast rc frequency through tuning register
// - low power rc tick also feeds watchdog and fail-safe monitor reference
// - power-on source comes from configuration select and primary mode fields
// - erased configuration starts from an internal fast rc selection
// - oscillator or pll output halved for instruction clock and peripheral base
// - pll input prescaled by two to thirty-three from five-bit field
// - vco input multiplied by feedback factor from nine-bit field
// - vco output postscaled by two, four or eight from bits seven to six
// - pll output equals input times feedback over prescale times postscale
// - select codes 000 to 111 map to the eight oscillator modes
// - erased device defaults to fast rc with divide-by-n postscaler
module system_clock_select_pll (
  // clock and reset
  input wire CLK,
  input wire ARST_N,
  // register port
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WRITE,
  input wire REG_READ,
  output reg [15:0] REG_RDATA,
  // configuration memory
  input wire [2:0] CONFIG_OSC_SELECT,
  input wire [1:0] CONFIG_PRIMARY_MODE,
  // oscillator pins
  input wire FAST_RC_CLK,
  input wire PRIMARY_CLK,
  input wire SECONDARY_CLK,
  input wire LOW_POWER_RC_CLK,
  // oscillator control
  output reg [5:0] FAST_RC_TUNE,
  output reg [1:0] PRIMARY_MODE,
  output reg PRIMARY_ENABLE,
  output reg SECONDARY_ENABLE,
  output reg PLL_ACTIVE,
  // derived timing
  output reg OSC_TICK,
  output reg INSTR_TICK,
  output reg PERIPH_TICK,
  output reg REFERENCE_TICK
);

  // ==========================================================
  // power-on selection capture
  // config fields are taken once, on the first edge after reset
  reg loaded_ff;
  reg [2:0] osc_sel_ff;
  reg [1:0] pmode_ff;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      loaded_ff <= 1'b0;
      osc_sel_ff <= `OSC_FRC_DIVN;
      pmode_ff <= `PMODE_OFF;
    end else if (!loaded_ff) begin
      loaded_ff <= 1'b1;
      osc_sel_ff <= CONFIG_OSC_SELECT;
      pmode_ff <= CONFIG_PRIMARY_MODE;
    end
  end

  // ==========================================================
  // oscillator pin synchronisers and edge detect
  // two flops tame metastability; the third only remembers the last level
  wire [`SRC_COUNT-1:0] osc_pin;
  wire [`SRC_COUNT-1:0] osc_rise;

  assign osc_pin[`SRC_FRC] = FAST_RC_CLK;
  assign osc_pin[`SRC_PRI] = PRIMARY_CLK;
  assign osc_pin[`SRC_SEC] = SECONDARY_CLK;
  assign osc_pin[`SRC_LOW_POWER_RC_OSCILLATOR] = LOW_POWER_RC_CLK;

  genvar g;
  generate
    for (g = 0; g < `SRC_COUNT; g = g + 1) begin : sync
      reg meta_ff;
      reg level_ff;
      reg last_ff;
      always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          meta_ff <= 1'b0;
          level_ff <= 1'b0;
          last_ff <= 1'b0;
        end else begin
          meta_ff <= osc_pin[g];
          level_ff <= meta_ff;
          last_ff <= level_ff;
        end
      end
      assign osc_rise[g] = level_ff & ~last_ff;
    end
  endgenerate

  // ==========================================================
  // software registers
  // a reserved postscale code leaves the old value in place
  reg [2:0] frc_div_ff;
  reg [1:0] post_ff;
  reg [4:0] pre_ff;
  reg [8:0] fbd_ff;
  reg [5:0] tune_ff;

  wire wr_cdiv = REG_WRITE && (REG_ADDR == `ADDR_CLOCK_DIVISOR);
  wire wr_fbd = REG_WRITE && (REG_ADDR == `ADDR_PLL_FEEDBACK);
  wire wr_tune = REG_WRITE && (REG_ADDR == `ADDR_FAST_RC_TUNING);
  wire [1:0] post_wr = REG_WDATA[`CDIV_POST_HI:`CDIV_POST_LO];

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      frc_div_ff <= `RST_FRC_DIV;
      post_ff <= `RST_POST;
      pre_ff <= `RST_PRE;
      fbd_ff <= `RST_FBD;
      tune_ff <= `RST_TUNE;
    end else begin
      if (wr_cdiv) begin
        frc_div_ff <= REG_WDATA[`CDIV_FRC_DIV_HI:`CDIV_FRC_DIV_LO];
        pre_ff <= REG_WDATA[`CDIV_PRE_HI:`CDIV_PRE_LO];
        if (post_wr != `POST_RSVD) begin
          post_ff <= post_wr;
        end
      end
      if (wr_fbd) begin
        fbd_ff <= REG_WDATA[`FBD_HI:`FBD_LO];
      end
      if (wr_tune) begin
        tune_ff <= REG_WDATA[`TUNE_HI:`TUNE_LO];
      end
    end
  end

  // ==========================================================
  // mode decode
  wire is_pll = (osc_sel_ff == `OSC_FRC_PLL) || (osc_sel_ff == `OSC_PRI_PLL);
  wire is_primary = (osc_sel_ff == `OSC_PRI) || (osc_sel_ff == `OSC_PRI_PLL);
  wire pri_on = is_primary && (pmode_ff != `PMODE_OFF);
  wire pri_tick = osc_rise[`SRC_PRI] & pri_on;

  // ==========================================================
  // fast rc divider, fixed by sixteen or by n
  // field n gives a span of two to the power n plus one
  reg [7:0] frc_cnt_ff;
  reg [7:0] nxt_frc_cnt;
  wire [8:0] frc_span = `FRC_DIVN_BASE << frc_div_ff;
  wire [8:0] frc_span_m1 = frc_span - 9'h001;
  wire [7:0] frc_last = (osc_sel_ff == `OSC_FRC_DIV16) ? `FRC_DIV16_LAST : frc_span_m1[7:0];
  wire frc_div_tick = osc_rise[`SRC_FRC] && (frc_cnt_ff >= frc_last);

  always @* begin
    nxt_frc_cnt = frc_cnt_ff;
    if (osc_rise[`SRC_FRC]) begin
      if (frc_cnt_ff >= frc_last) begin
        nxt_frc_cnt = 8'h00;
      end else begin
        nxt_frc_cnt = frc_cnt_ff + 8'h01;
      end
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      frc_cnt_ff <= 8'h00;
    end else begin
      frc_cnt_ff <= nxt_frc_cnt;
    end
  end

  // ==========================================================
  // pll prescaler
  // passes every n-th raw source edge on to the vco input
  wire pll_in = (osc_sel_ff == `OSC_FRC_PLL) ? osc_rise[`SRC_FRC] :
                (osc_sel_ff == `OSC_PRI_PLL) ? pri_tick : 1'b0;
  wire [5:0] pre_factor = {1'b0, pre_ff} + `PRE_OFFSET;
  wire [5:0] pre_last = pre_factor - 6'h01;
  reg [5:0] pre_cnt_ff;
  reg [5:0] nxt_pre_cnt;
  wire vco_in = pll_in && (pre_cnt_ff >= pre_last);

  always @* begin
    nxt_pre_cnt = pre_cnt_ff;
    if (!is_pll) begin
      nxt_pre_cnt = 6'h00;
    end else if (pll_in) begin
      if (pre_cnt_ff >= pre_last) begin
        nxt_pre_cnt = 6'h00;
      end else begin
        nxt_pre_cnt = pre_cnt_ff + 6'h01;
      end
    end
  end

  // ==========================================================
  // feedback multiply and postscale as a credit accumulator
  wire [9:0] fbd_factor = {1'b0, fbd_ff} + `FBD_OFFSET;
  reg [1:0] post_shift;

  always @* begin
    case (post_ff)
      `POST_DIV2: post_shift = `POST_SHIFT2;
      `POST_DIV4: post_shift = `POST_SHIFT4;
      `POST_DIV8: post_shift = `POST_SHIFT8;
      default: post_shift = `POST_SHIFT2;
    endcase
  end

  // only the postscale is spent per output: the prescaler already thinned the vco input
  // so the average rate is input times feedback over prescale times postscale
  wire [8:0] pll_div = `POST_BASE << post_shift;
  reg [10:0] acc_ff;
  reg [11:0] nxt_acc;
  wire pll_tick = is_pll && ({1'b0, acc_ff} >= {3'h0, pll_div});

  // each vco input adds the feedback factor; each output spends the divisor
  always @* begin
    nxt_acc = {1'b0, acc_ff};
    if (vco_in) begin
      nxt_acc = nxt_acc + {2'h0, fbd_factor};
    end
    if (pll_tick) begin
      nxt_acc = nxt_acc - {3'h0, pll_div};
    end
    // saturation keeps a too-fast request from wrapping the credit
    if (!is_pll) begin
      nxt_acc = 12'h000;
    end else if (nxt_acc > `ACC_MAX) begin
      nxt_acc = `ACC_MAX;
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_cnt_ff <= 6'h00;
      acc_ff <= 11'h000;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      acc_ff <= nxt_acc[10:0];
    end
  end

  // ==========================================================
  // system clock source select
  // both postscaled fast rc modes share one divider; the mode picks its span
  reg src_tick;

  always @* begin
    case (osc_sel_ff)
      `OSC_FRC: src_tick = osc_rise[`SRC_FRC];
      `OSC_FRC_PLL: src_tick = pll_tick;
      `OSC_PRI: src_tick = pri_tick;
      `OSC_PRI_PLL: src_tick = pll_tick;
      `OSC_SEC: src_tick = osc_rise[`SRC_SEC];
      `OSC_LOW_POWER_RC_OSCILLATOR: src_tick = osc_rise[`SRC_LOW_POWER_RC_OSCILLATOR];
      `OSC_FRC_DIV16: src_tick = frc_div_tick;
      `OSC_FRC_DIVN: src_tick = frc_div_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // halving stage and output registers
  // no tick leaves before the configuration has been captured
  reg half_ff;
  wire gated_tick = src_tick & loaded_ff;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      half_ff <= 1'b0;
      OSC_TICK <= 1'b0;
      INSTR_TICK <= 1'b0;
      PERIPH_TICK <= 1'b0;
      REFERENCE_TICK <= 1'b0;
      FAST_RC_TUNE <= `RST_TUNE;
      PRIMARY_MODE <= `PMODE_OFF;
      PRIMARY_ENABLE <= 1'b0;
      SECONDARY_ENABLE <= 1'b0;
      PLL_ACTIVE <= 1'b0;
    end else begin
      if (gated_tick) begin
        half_ff <= ~half_ff;
      end
      OSC_TICK <= gated_tick;
      INSTR_TICK <= gated_tick & half_ff;
      PERIPH_TICK <= gated_tick & half_ff;
      REFERENCE_TICK <= osc_rise[`SRC_LOW_POWER_RC_OSCILLATOR];
      FAST_RC_TUNE <= tune_ff;
      PRIMARY_MODE <= pri_on ? pmode_ff : `PMODE_OFF;
      PRIMARY_ENABLE <= loaded_ff & pri_on;
      SECONDARY_ENABLE <= loaded_ff & (osc_sel_ff == `OSC_SEC);
      PLL_ACTIVE <= loaded_ff & is_pll;
    end
  end

  // ==========================================================
  // register read port
  // read data stands for one cycle only and reads zero otherwise
  reg [15:0] rd_word;

  always @* begin
    rd_word = `RST_DATA;
    case (REG_ADDR)
      `ADDR_CLOCK_DIVISOR: begin
        rd_word[`CDIV_FRC_DIV_HI:`CDIV_FRC_DIV_LO] = frc_div_ff;
        rd_word[`CDIV_POST_HI:`CDIV_POST_LO] = post_ff;
        rd_word[`CDIV_PRE_HI:`CDIV_PRE_LO] = pre_ff;
      end
      `ADDR_PLL_FEEDBACK: begin
        rd_word[`FBD_HI:`FBD_LO] = fbd_ff;
      end
      `ADDR_FAST_RC_TUNING: begin
        rd_word[`TUNE_HI:`TUNE_LO] = tune_ff;
      end
      `ADDR_CLOCK_STATUS: begin
        rd_word[`STAT_SEL_HI:`STAT_SEL_LO] = osc_sel_ff;
        rd_word[`STAT_MODE_HI:`STAT_MODE_LO] = pmode_ff;
        rd_word[`STAT_PLL_BIT] = is_pll;
        rd_word[`STAT_LOADED_BIT] = loaded_ff;
      end
      default: begin
        rd_word = `RST_DATA;
      end
    endcase
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= `RST_DATA;
    end else begin
      REG_RDATA <= REG_READ ? rd_word : `RST_DATA;
    end
  end

endmodule // system_clock_select_pll

// File: system_clock_select_pll_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module system_clock_select_pll_chk (
  // clock and reset
  input wire CLK,
  input wire ARST_N,
  // register port
  input wire [3:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire REG_WRITE,
  input wire REG_READ,
  input wire [15:0] REG_RDATA,
  // configuration and pins
  input wire [2:0] CONFIG_OSC_SELECT,
  input wire [1:0] CONFIG_PRIMARY_MODE,
  input wire FAST_RC_CLK,
  input wire LOW_POWER_RC_CLK,
  // outputs
  input wire [5:0] FAST_RC_TUNE,
  input wire PRIMARY_ENABLE,
  input wire SECONDARY_ENABLE,
  input wire PLL_ACTIVE,
  input wire OSC_TICK,
  input wire INSTR_TICK,
  input wire PERIPH_TICK,
  input wire REFERENCE_TICK
);
  reg osc_odd_ff;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // parity of system ticks since reset
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) osc_odd_ff <= 1'b0;
    else if (OSC_TICK) osc_odd_ff <= ~osc_odd_ff;
  end
  chk_instr_pairing: assert property (INSTR_TICK == (OSC_TICK && osc_odd_ff))
    else $error("instruction tick not on every second system tick");
  chk_periph_same: assert property (PERIPH_TICK == INSTR_TICK)
    else $error("peripheral tick differs from instruction tick");
  chk_frc_latency: assert property (ARST_N && (CONFIG_OSC_SELECT == 3'h0) && $rose(FAST_RC_CLK) |-> ##3 OSC_TICK)
    else $error("fast rc edge gave no system tick");
  chk_ref_tick: assert property ($rose(LOW_POWER_RC_CLK) |-> ##[3:5] REFERENCE_TICK)
    else $error("low power rc edge gave no reference tick");
  chk_tune_write: assert property ((REG_WRITE && REG_ADDR == 4'h2) |-> ##[1:2]
    ({10'h000, FAST_RC_TUNE} == ($past(REG_WDATA) & 16'h003F)))
    else $error("tuning output not updated by write");
  chk_status_sel: assert property ((REG_READ && REG_ADDR == 4'h3) |=>
    REG_RDATA[2:0] == CONFIG_OSC_SELECT)
    else $error("status select differs from configuration");
  chk_pll_flag: assert property (PLL_ACTIVE |-> CONFIG_OSC_SELECT inside {3'h1, 3'h3})
    else $error("pll active in a non pll mode");
  chk_sec_enable: assert property (SECONDARY_ENABLE |-> CONFIG_OSC_SELECT == 3'h4)
    else $error("secondary enabled in wrong mode");
  chk_pri_enable: assert property (PRIMARY_ENABLE |-> CONFIG_OSC_SELECT[2:1] == 2'h1
    && CONFIG_PRIMARY_MODE != 2'h3)
    else $error("primary enabled in wrong mode");
endmodule // system_clock_select_pll_chk

bind system_clock_select_pll system_clock_select_pll_chk i_chk (
  .CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
  .CONFIG_OSC_SELECT(CONFIG_OSC_SELECT), .CONFIG_PRIMARY_MODE(CONFIG_PRIMARY_MODE),
  .FAST_RC_CLK(FAST_RC_CLK), .LOW_POWER_RC_CLK(LOW_POWER_RC_CLK),
  .FAST_RC_TUNE(FAST_RC_TUNE), .PRIMARY_ENABLE(PRIMARY_ENABLE),
  .SECONDARY_ENABLE(SECONDARY_ENABLE), .PLL_ACTIVE(PLL_ACTIVE), .OSC_TICK(OSC_TICK),
  .INSTR_TICK(INSTR_TICK), .PERIPH_TICK(PERIPH_TICK), .REFERENCE_TICK(REFERENCE_TICK));

// File: osc_sources_model.sv
`timescale 1ns/1ps
// ==========================================================
// oscillator pins; primary and secondary swing only while enabled
module osc_sources_model (
  // clock
  input wire clk,
  // oscillator control
  input wire [5:0] tune,
  input wire pri_en,
  input wire sec_en,
  // oscillator pins
  output wire fast_rc_oscillator,
  output wire pri,
  output wire sec,
  output wire low_power_rc_oscillator
);
  reg [3:0] cnt_ff [0:3] = '{4'h0, 4'h0, 4'h0, 4'h0};
  reg ph_ff [0:3] = '{1'b0, 1'b0, 1'b0, 1'b0};
  int lim;
  // trim bit 0 slows the fast rc
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      lim = (i == 0) ? (tune[0] ? 3 : 2) : i + 2;
      if (cnt_ff[i] >= lim - 1) begin
        cnt_ff[i] <= 4'h0;
        ph_ff[i] <= ~ph_ff[i];
      end else begin
        cnt_ff[i] <= cnt_ff[i] + 4'h1;
      end
    end
  end
  assign fast_rc_oscillator = ph_ff[0];
  assign pri = ph_ff[1] & pri_en;
  assign sec = ph_ff[2] & sec_en;
  assign low_power_rc_oscillator = ph_ff[3];
endmodule // osc_sources_model

// File: system_clock_select_pll_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench top
module system_clock_select_pll_tb_top;
  reg CLK = 1'b0;
  reg ARST_N = 1'b0;
  reg [3:0] REG_ADDR = 4'h0;
  reg [15:0] REG_WDATA = 16'h0000;
  reg REG_WRITE = 1'b0;
  reg REG_READ = 1'b0;
  reg [2:0] CONFIG_OSC_SELECT = 3'h7;
  reg [1:0] CONFIG_PRIMARY_MODE = 2'h3;
  wire FAST_RC_CLK, PRIMARY_CLK, SECONDARY_CLK, LOW_POWER_RC_CLK;
  wire [15:0] REG_RDATA;
  wire [5:0] FAST_RC_TUNE;
  wire [1:0] PRIMARY_MODE;
  wire PRIMARY_ENABLE, SECONDARY_ENABLE, PLL_ACTIVE;
  wire OSC_TICK, INSTR_TICK, PERIPH_TICK, REFERENCE_TICK;
  int err_total = 0;
  int checked = 0;
  always #4 CLK = ~CLK;
  system_clock_select_pll i_dut (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
    .CONFIG_OSC_SELECT(CONFIG_OSC_SELECT), .CONFIG_PRIMARY_MODE(CONFIG_PRIMARY_MODE),
    .FAST_RC_CLK(FAST_RC_CLK), .PRIMARY_CLK(PRIMARY_CLK), .SECONDARY_CLK(SECONDARY_CLK),
    .LOW_POWER_RC_CLK(LOW_POWER_RC_CLK), .FAST_RC_TUNE(FAST_RC_TUNE),
    .PRIMARY_MODE(PRIMARY_MODE), .PRIMARY_ENABLE(PRIMARY_ENABLE),
    .SECONDARY_ENABLE(SECONDARY_ENABLE), .PLL_ACTIVE(PLL_ACTIVE), .OSC_TICK(OSC_TICK),
    .INSTR_TICK(INSTR_TICK), .PERIPH_TICK(PERIPH_TICK), .REFERENCE_TICK(REFERENCE_TICK));
  osc_sources_model i_osc (.clk(CLK), .tune(FAST_RC_TUNE), .pri_en(PRIMARY_ENABLE),
    .sec_en(SECONDARY_ENABLE), .fast_rc_oscillator(FAST_RC_CLK), .pri(PRIMARY_CLK), .sec(SECONDARY_CLK),
    .low_power_rc_oscillator(LOW_POWER_RC_CLK));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= 1'b1;
    @(posedge CLK);
    REG_WRITE <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_READ <= 1'b1;
    @(posedge CLK);
    REG_READ <= 1'b0;
    #1 check(what, {16'h0000, REG_RDATA}, {16'h0000, exp});
  endtask
  task automatic do_reset(input logic [2:0] sel, input logic [1:0] mode);
    @(posedge CLK);
    ARST_N <= 1'b0;
    CONFIG_OSC_SELECT <= sel;
    CONFIG_PRIMARY_MODE <= mode;
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
  endtask
  function automatic logic pin(input int s);
    case (s)
      0: return FAST_RC_CLK;
      1: return PRIMARY_CLK;
      2: return SECONDARY_CLK;
      default: return LOW_POWER_RC_CLK;
    endcase
  endfunction
  // counts source edges against system ticks over a fixed window
  task automatic meas(input int s, input int num, input int den);
    int r = 0;
    int o = 0;
    int it = 0;
    int lr = 0;
    int rt = 0;
    int pm = 0;
    logic prev;
    logic lprev;
    prev = pin(s);
    lprev = LOW_POWER_RC_CLK;
    repeat (600) begin
      @(posedge CLK);
      #1;
      if (pin(s) === 1'b1 && prev === 1'b0) r++;
      prev = pin(s);
      if (LOW_POWER_RC_CLK === 1'b1 && lprev === 1'b0) lr++;
      lprev = LOW_POWER_RC_CLK;
      if (OSC_TICK === 1'b1) o++;
      if (INSTR_TICK === 1'b1) it++;
      if (REFERENCE_TICK === 1'b1) rt++;
      if (PERIPH_TICK !== INSTR_TICK) pm++;
    end
    check("periph tick", pm, 0);
    check("reference rate", (lr - rt) * (lr - rt) <= 1, 1);
    check("osc rate", (o * den - r * num <= 2 * den) && (r * num - o * den <= 2 * den), 1);
    check("instr rate", (o - 2 * it) * (o - 2 * it) <= 1, 1);
  endtask
  task automatic run_case(input logic [2:0] sel, input logic [1:0] mode, input int s,
    input logic [15:0] cdiv, input logic [15:0] fbd, input int num, input int den);
    logic pll;
    logic pri;
    pll = (sel == 3'h1) || (sel == 3'h3);
    pri = (sel == 3'h2 || sel == 3'h3) && mode != 2'h3;
    do_reset(sel, mode);
    wr(4'h0, cdiv);
    wr(4'h1, fbd);
    rd(4'h3, {8'h00, 1'b1, pll, mode, 1'b0, sel}, "status");
    check("pll active", PLL_ACTIVE, pll);
    check("secondary enable", SECONDARY_ENABLE, sel == 3'h4);
    check("primary enable", PRIMARY_ENABLE, pri);
    check("primary mode", PRIMARY_MODE, pri ? mode : 2'h3);
    meas(s, num, den);
  endtask
  initial begin
    do_reset(3'h7, 2'h3);
    rd(4'h0, 16'h0000, "divisor reset");
    rd(4'h1, 16'h0030, "feedback reset");
    rd(4'h3, 16'h00B7, "erased status");
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000, "unmapped");
    wr(4'h2, 16'hFFEB);
    rd(4'h2, 16'h002B, "tuning");
    check("tune pins", FAST_RC_TUNE, 6'h2B);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'h07DF, "divisor");
    wr(4'h0, 16'h0080);
    rd(4'h0, 16'h00C0, "reserved postscale");
    wr(4'h1, 16'hFFFF);
    rd(4'h1, 16'h01FF, "feedback");
    wr(4'h0, 16'h0000);
    meas(0, 1, 2);
    run_case(3'h7, 2'h3, 0, 16'h0200, 16'h0030, 1, 8);
    run_case(3'h0, 2'h3, 0, 16'h0000, 16'h0030, 1, 1);
    run_case(3'h6, 2'h3, 0, 16'h0000, 16'h0030, 1, 16);
    run_case(3'h4, 2'h3, 2, 16'h0000, 16'h0030, 1, 1);
    run_case(3'h5, 2'h3, 3, 16'h0000, 16'h0030, 1, 1);
    run_case(3'h2, 2'h1, 1, 16'h0000, 16'h0030, 1, 1);
    run_case(3'h2, 2'h0, 1, 16'h0000, 16'h0030, 1, 1);
    run_case(3'h2, 2'h3, 1, 16'h0000, 16'h0030, 0, 1);
    run_case(3'h3, 2'h2, 1, 16'h0000, 16'h0002, 1, 1);
    run_case(3'h1, 2'h3, 0, 16'h0040, 16'h0000, 1, 4);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    report_and_stop;
  end
endmodule // system_clock_select_pll_tb_top
